// ==== hpc_host_port.sv ====
`timescale 1ns/1ps
module hpc_host_port (
    input  wire logic        clk_in,              // 200 MHz clock
    input  wire logic        reset_in,            // async reset, high
    input  wire logic        host_read_in,        // host read strobe
    input  wire logic        host_write_in,       // host write strobe
    input  wire logic [2:0]  host_addr_in,        // host address lines
    input  wire logic [7:0]  host_data_in,        // host data bus in
    output logic [7:0]       host_data_out,       // host data bus out
    output logic             host_data_oe_out,    // drive data bus
    output logic             request_pin_out,     // request or tx req
    input  wire logic        ack_pin_in,          // ack / rx req pin in
    output logic             ack_pin_out,         // rx request level
    output logic             ack_pin_oe_out,      // drive rx request
    output logic             vector_ack_out,      // vectored ack pulse
    input  wire logic [2:0]  dsp_mode_select_in,  // dsp-side mode
    output logic             host_flag_zero_out,  // status flag 0
    output logic             host_flag_one_out,   // status flag 1
    input  wire logic [23:0] dsp_tx_word_in,      // dsp word to host
    input  wire logic        dsp_tx_load_in,      // load dsp word
    output logic             dsp_tx_word_empty_out, // dsp word free
    output logic             dsp_tx_event_out,    // word moved to host
    output logic [23:0]      dsp_rx_word_out,     // word from host
    output logic             dsp_rx_word_full_out,  // word waiting
    input  wire logic        dsp_rx_read_in,      // dsp takes word
    output logic             dsp_rx_event_out     // word from host in
);
    hpc_pkg::hpc_state_t s_reg;
    hpc_pkg::hpc_state_t s_next;

    logic       fifo_ready;
    logic       fifo_flush;
    logic       mode_plain;
    logic       mode_low_set;
    logic       mode_hostdma;
    logic [1:0] xfer_mode;
    logic       int_mode;
    logic       dma_mode;
    logic       rx_dir;
    logic       tx_dir;
    logic       rx_req;
    logic       tx_req;
    logic       order_swap;
    logic       rd_done;
    logic       wr_done;
    logic       dma_done;
    logic       ack_rise;
    logic [2:0] eff_addr;
    logic [1:0] byte_idx;
    logic [7:0] ctrl_view;
    logic [7:0] stat_view;
    logic [7:0] read_val;

    hpc_fifo #(
        .WIDTH (hpc_pkg::WORD_W),
        .DEPTH (hpc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .flush_in      (fifo_flush),
        .in_valid_in   (s_reg.tx_push),
        .in_ready_out  (fifo_ready),
        .in_data_in    (s_reg.tx_bytes),
        .out_valid_out (dsp_rx_word_full_out),
        .out_ready_in  (dsp_rx_read_in),
        .out_data_out  (dsp_rx_word_out)
    );

    // mode decode
    always_comb begin
        mode_plain   = (dsp_mode_select_in == hpc_pkg::MODE_PLAIN);
        mode_low_set = |dsp_mode_select_in[1:0];
        mode_hostdma = (dsp_mode_select_in == hpc_pkg::MODE_HOSTDMA);
        xfer_mode    = mode_hostdma ? {s_reg.bit6, s_reg.bit5}
                                    : hpc_pkg::XFER_INT;
        int_mode     = mode_plain
                     | (mode_hostdma & (xfer_mode == hpc_pkg::XFER_INT));
        dma_mode     = mode_hostdma & (xfer_mode != hpc_pkg::XFER_INT);
        order_swap   = mode_plain & s_reg.bit5;
        rx_dir       = s_reg.rx_request_enable & ~s_reg.tx_request_enable;
        tx_dir       = s_reg.tx_request_enable & ~s_reg.rx_request_enable;
    end

    // request generation; other dsp dma modes raise nothing
    always_comb begin
        rx_req = 1'b0;
        tx_req = 1'b0;
        if (int_mode) begin
            rx_req = s_reg.rx_request_enable & s_reg.rx_bytes_full;
            tx_req = s_reg.tx_request_enable & s_reg.tx_bytes_empty;
        end else if (dma_mode) begin
            rx_req = rx_dir & s_reg.rx_bytes_full;
            tx_req = tx_dir & s_reg.tx_bytes_empty;
        end
    end

    // shared pin functions
    always_comb begin
        if (s_reg.dual_request_select) begin
            request_pin_out = tx_req;
            ack_pin_out     = rx_req;
            ack_pin_oe_out  = 1'b1;
        end else begin
            request_pin_out = rx_req | tx_req;
            ack_pin_out     = 1'b0;
            ack_pin_oe_out  = 1'b0;
        end
    end

    // register views
    always_comb begin
        ctrl_view = {s_reg.init, 2'b00, s_reg.host_flag_one,
                     s_reg.host_flag_zero, s_reg.dual_request_select,
                     s_reg.tx_request_enable, s_reg.rx_request_enable};
        if (mode_low_set) begin
            ctrl_view[hpc_pkg::B_XFER_HI] = dsp_mode_select_in[1];
            ctrl_view[hpc_pkg::B_ORDER]   = dsp_mode_select_in[0];
        end else if (mode_hostdma) begin
            ctrl_view[hpc_pkg::B_XFER_HI] = s_reg.bit6;
            ctrl_view[hpc_pkg::B_ORDER]   = s_reg.bit5;
        end else if (mode_plain) begin
            ctrl_view[hpc_pkg::B_ORDER]   = s_reg.bit5;
        end
        stat_view = {(rx_req | tx_req), 4'h0,
                     s_reg.tx_bytes_empty & ~dsp_rx_word_full_out,
                     s_reg.tx_bytes_empty, s_reg.rx_bytes_full};
    end

    // byte selection: dma uses the counter with address line 2 high
    always_comb begin
        eff_addr = s_reg.addr_hold;
        if (dma_mode & s_reg.ack_lvl) begin
            eff_addr = {1'b1, s_reg.cnt};
        end
        byte_idx = eff_addr[1:0] - 2'h1;
        if (order_swap) begin
            byte_idx = 2'h2 - byte_idx;
        end
        case (eff_addr)
            hpc_pkg::ADDR_CTRL: read_val = ctrl_view;
            hpc_pkg::ADDR_STAT: read_val = stat_view;
            hpc_pkg::ADDR_FIRST,
            hpc_pkg::ADDR_MID,
            hpc_pkg::ADDR_LAST: begin
                read_val = s_reg.rx_bytes[(2'h2 - byte_idx) * 8 +: 8];
            end
            default: read_val = hpc_pkg::BYTE_ZERO;
        endcase
    end

    assign rd_done  = ~s_next.rd_lvl & s_reg.rd_lvl;
    assign wr_done  = ~s_next.wr_lvl & s_reg.wr_lvl;
    assign dma_done = dma_mode & s_reg.ack_lvl & ~s_next.ack_lvl;
    assign ack_rise = s_next.ack_lvl & ~s_reg.ack_lvl;
    assign fifo_flush = s_reg.init & s_reg.tx_request_enable;

    always_comb begin
        s_next = s_reg;
        s_next.rd_sync  = {s_reg.rd_sync[1:0], host_read_in};
        s_next.wr_sync  = {s_reg.wr_sync[1:0], host_write_in};
        s_next.ack_sync = {s_reg.ack_sync[1:0],
                           ack_pin_in & ~s_reg.dual_request_select};
        if (s_reg.rd_sync[1] == s_reg.rd_sync[2]) begin
            s_next.rd_lvl = s_reg.rd_sync[2];
        end
        if (s_reg.wr_sync[1] == s_reg.wr_sync[2]) begin
            s_next.wr_lvl = s_reg.wr_sync[2];
        end
        if (s_reg.ack_sync[1] == s_reg.ack_sync[2]) begin
            s_next.ack_lvl = s_reg.ack_sync[2];
        end
        if (s_reg.rd_lvl | s_reg.wr_lvl) begin
            s_next.addr_hold = host_addr_in;
            s_next.data_hold = host_data_in;
        end else if (s_reg.ack_lvl) begin
            s_next.data_hold = host_data_in;
        end
        s_next.rd_data  = read_val;
        s_next.drive    = s_reg.rd_lvl
                        | (dma_mode & rx_dir & s_reg.ack_lvl);
        s_next.rx_event = 1'b0;
        s_next.tx_event = 1'b0;
        s_next.vec_ack  = int_mode & ~s_reg.dual_request_select
                        & ack_rise & (rx_req | tx_req);

        if (!dma_mode) begin
            s_next.cnt = xfer_mode;
        end

        // control register write
        if (wr_done & (s_reg.addr_hold == hpc_pkg::ADDR_CTRL)) begin
            s_next.rx_request_enable   = s_reg.data_hold[hpc_pkg::B_RX_EN];
            s_next.tx_request_enable   = s_reg.data_hold[hpc_pkg::B_TX_EN];
            s_next.dual_request_select = s_reg.data_hold[hpc_pkg::B_DUAL];
            s_next.host_flag_zero = s_reg.data_hold[hpc_pkg::B_FLAG0];
            s_next.host_flag_one  = s_reg.data_hold[hpc_pkg::B_FLAG1];
            if (!mode_low_set) begin
                s_next.bit5 = s_reg.data_hold[hpc_pkg::B_ORDER];
            end
            if (mode_hostdma) begin
                s_next.bit6 = s_reg.data_hold[hpc_pkg::B_XFER_HI];
            end
            s_next.init = s_reg.data_hold[hpc_pkg::B_INIT];
        end

        // data byte write by host or by dma acknowledge
        if ((wr_done & s_reg.addr_hold[2] & (s_reg.addr_hold != 3'h4))
            | (dma_done & tx_dir)) begin
            s_next.tx_bytes[(2'h2 - byte_idx) * 8 +: 8] = s_reg.data_hold;
            if ((eff_addr == hpc_pkg::ADDR_LAST) & s_reg.tx_bytes_empty) begin
                s_next.tx_bytes[(2'h2 - byte_idx) * 8 +: 8] = s_reg.data_hold;
                s_next.tx_bytes_empty = 1'b0;
                s_next.tx_push        = 1'b1;
            end
        end

        // last byte read frees the receive bytes
        if (((rd_done & ~dma_mode) | (dma_done & rx_dir))
            & (eff_addr == hpc_pkg::ADDR_LAST)) begin
            s_next.rx_bytes_full = 1'b0;
        end

        if (dma_done) begin
            s_next.cnt = (s_reg.cnt == hpc_pkg::CNT_LOW) ? xfer_mode
                                                         : s_reg.cnt + 2'h1;
        end

        // word moves; one dsp event per whole word
        if (s_reg.tx_push & fifo_ready) begin
            s_next.tx_push        = 1'b0;
            s_next.tx_bytes_empty = 1'b1;
            s_next.rx_event       = 1'b1;
        end
        if (dsp_tx_load_in & ~s_reg.dsp_tx_full) begin
            s_next.dsp_to_host_word = dsp_tx_word_in;
            s_next.dsp_tx_full      = 1'b1;
        end
        if (s_reg.dsp_tx_full & ~s_reg.rx_bytes_full) begin
            s_next.rx_bytes      = s_reg.dsp_to_host_word;
            s_next.rx_bytes_full = 1'b1;
            s_next.dsp_tx_full   = dsp_tx_load_in;
            s_next.dsp_to_host_word = dsp_tx_word_in;
            s_next.tx_event      = 1'b1;
        end

        // initialize command, one cycle after the write
        if (s_reg.init) begin
            s_next.init = 1'b0;
            s_next.cnt  = xfer_mode;
            if (s_reg.rx_request_enable) begin
                s_next.rx_bytes_full = 1'b0;
                s_next.dsp_tx_full   = 1'b0;
                s_next.tx_event      = 1'b0;
            end
            if (s_reg.tx_request_enable) begin
                s_next.tx_bytes_empty = 1'b1;
                s_next.tx_push        = 1'b0;
                s_next.rx_event       = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_reg                <= '0;
            s_reg.tx_bytes_empty <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign host_data_out         = s_reg.rd_data;
    assign host_data_oe_out      = s_reg.drive;
    assign vector_ack_out        = s_reg.vec_ack;
    assign host_flag_zero_out    = s_reg.host_flag_zero;
    assign host_flag_one_out     = s_reg.host_flag_one;
    assign dsp_tx_word_empty_out = ~s_reg.dsp_tx_full;
    assign dsp_tx_event_out      = s_reg.tx_event;
    assign dsp_rx_event_out      = s_reg.rx_event;
endmodule : hpc_host_port

// ==== hpc_pkg.sv ====
// Contract
// - control register is host bus only, 8 bits
// - bits 5, 6 depend on dsp mode select
// - mode low bits set: bits 6,5 mirror them
// - interrupt mode: rx enable requests while rx full
// - interrupt mode: tx enable requests while tx empty
// - other dsp dma modes ignore both enables
// - single pin ors requests; dual pins split them
// - dma: pins carry direction requests; both reserved
// - bit 2 selects shared pin functions
// - host flags writable by host, seen by dsp
// - byte order bit swaps high and low addresses
// - byte order only in mode 000; bit 6 zero
// - interrupt mode: acknowledge is vector acknowledge
// - dma: acknowledge strobes selected byte on bus
// - dma byte counter preloaded, address line 2 high
// - counter advances, reloads after low byte
// - one dsp word event per whole dma word
// - init bit self-clears after command
// - init acts per request enables
// - rx full sets on word move, clears last read
// - tx empty sets on word move, clears last write
package hpc_pkg;
    localparam int          BYTE_W      = 8;
    localparam int          WORD_W      = 24;
    localparam int          FIFO_DEPTH  = 8;
    localparam logic [2:0]  ADDR_CTRL   = 3'h0;
    localparam logic [2:0]  ADDR_STAT   = 3'h2;
    localparam logic [2:0]  ADDR_FIRST  = 3'h5;
    localparam logic [2:0]  ADDR_MID    = 3'h6;
    localparam logic [2:0]  ADDR_LAST   = 3'h7;
    localparam logic [2:0]  MODE_PLAIN  = 3'h0;
    localparam logic [2:0]  MODE_HOSTDMA = 3'h4;
    localparam logic [1:0]  XFER_INT    = 2'h0;
    localparam logic [1:0]  CNT_LOW     = 2'h3;
    localparam int          B_RX_EN     = 0;
    localparam int          B_TX_EN     = 1;
    localparam int          B_DUAL      = 2;
    localparam int          B_FLAG0     = 3;
    localparam int          B_FLAG1     = 4;
    localparam int          B_ORDER     = 5;
    localparam int          B_XFER_HI   = 6;
    localparam int          B_INIT      = 7;
    localparam int          B_STAT_REQ  = 7;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;

    typedef struct packed {
        logic [2:0]  rd_sync;
        logic [2:0]  wr_sync;
        logic [2:0]  ack_sync;
        logic        rd_lvl;
        logic        wr_lvl;
        logic        ack_lvl;
        logic [2:0]  addr_hold;
        logic [7:0]  data_hold;
        logic        rx_request_enable;
        logic        tx_request_enable;
        logic        dual_request_select;
        logic        host_flag_zero;
        logic        host_flag_one;
        logic        bit5;
        logic        bit6;
        logic        init;
        logic [1:0]  cnt;
        logic        rx_bytes_full;
        logic        tx_bytes_empty;
        logic        tx_push;
        logic [23:0] rx_bytes;
        logic [23:0] tx_bytes;
        logic [23:0] dsp_to_host_word;
        logic        dsp_tx_full;
        logic [7:0]  rd_data;
        logic        drive;
        logic        rx_event;
        logic        tx_event;
        logic        vec_ack;
    } hpc_state_t;
endpackage : hpc_pkg

// ==== hpc_fifo.sv ====
`timescale 1ns/1ps
module hpc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,       // clock
    input  wire logic             reset_in,     // async reset, high
    input  wire logic             flush_in,     // drop all entries
    input  wire logic             in_valid_in,  // write request
    output logic                  in_ready_out, // room available
    input  wire logic [WIDTH-1:0] in_data_in,   // write data
    output logic                  out_valid_out,// entry available
    input  wire logic             out_ready_in, // read accept
    output logic [WIDTH-1:0]      out_data_out  // head entry
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 count;
    } hpc_fifo_state_t;

    hpc_fifo_state_t s_reg;
    hpc_fifo_state_t s_next;
    logic            push;
    logic            pop;

    assign in_ready_out  = (s_reg.count != (AW+1)'(DEPTH));
    assign out_valid_out = (s_reg.count != '0);
    assign out_data_out  = s_reg.mem[s_reg.rp];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wp] = in_data_in;
            s_next.wp = (s_reg.wp == AW'(DEPTH - 1)) ? '0 : s_reg.wp + 1'b1;
        end
        if (pop) begin
            s_next.rp = (s_reg.rp == AW'(DEPTH - 1)) ? '0 : s_reg.rp + 1'b1;
        end
        s_next.count = s_reg.count + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_in) begin
            s_next.wp    = '0;
            s_next.rp    = '0;
            s_next.count = '0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : hpc_fifo

// ==== hpc_host_port_properties.sv ====
`timescale 1ns/1ps
module hpc_host_port_checker (
    input wire logic       clk_in,               // clock
    input wire logic       reset_in,             // async reset, high
    input wire logic       host_read_in,         // read strobe
    input wire logic       host_write_in,        // write strobe
    input wire logic       host_data_oe_out,     // bus drive
    input wire logic       request_pin_out,      // request pin
    input wire logic       ack_pin_in,           // ack pin level
    input wire logic       ack_pin_out,          // rx request level
    input wire logic       ack_pin_oe_out,       // rx request drive
    input wire logic       vector_ack_out,       // vector ack pulse
    input wire logic [2:0] dsp_mode_select_in,   // dsp-side mode
    input wire logic       host_flag_zero_out,   // flag 0
    input wire logic       host_flag_one_out,    // flag 1
    input wire logic       dsp_rx_word_full_out, // fifo not empty
    input wire logic       dsp_rx_read_in,       // fifo pop
    input wire logic       dsp_rx_event_out      // word event
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_oe_cause: assert property ($rose(host_data_oe_out) |->
        $past(host_read_in, 4) || $past(ack_pin_in, 4))
        else $error("bus driven without strobe");
    a_oe_release: assert property (
        (!host_read_in && !ack_pin_in)[*6] |-> !host_data_oe_out)
        else $error("bus still driven after strobe");
    a_flags_hold: assert property ((!host_write_in)[*8] |=>
        $stable({host_flag_one_out, host_flag_zero_out}))
        else $error("host flag moved without write");
    a_vec_pulse: assert property (vector_ack_out |->
        ($past(ack_pin_in, 2) && !ack_pin_oe_out) ##1 !vector_ack_out)
        else $error("vector ack without cause");
    a_rx_pin_gated: assert property (
        !ack_pin_oe_out |-> !ack_pin_out)
        else $error("rx request while pin is input");
    a_mode_silent: assert property (
        (dsp_mode_select_in[1:0] != 2'h0)[*3] |->
        !request_pin_out && !ack_pin_out)
        else $error("request in ignored mode");
    a_fifo_pop: assert property ((!host_write_in)[*8] ##1
        $fell(dsp_rx_word_full_out) |-> $past(dsp_rx_read_in))
        else $error("fifo emptied without pop");
    a_event_word: assert property (dsp_rx_event_out |->
        ##[0:2] dsp_rx_word_full_out)
        else $error("word event without word");
endmodule : hpc_host_port_checker

bind hpc_host_port hpc_host_port_checker chk_i (
    .clk_in(clk_in), .reset_in(reset_in), .host_read_in(host_read_in),
    .host_write_in(host_write_in), .host_data_oe_out(host_data_oe_out),
    .request_pin_out(request_pin_out), .ack_pin_in(ack_pin_in),
    .ack_pin_out(ack_pin_out), .ack_pin_oe_out(ack_pin_oe_out),
    .vector_ack_out(vector_ack_out),
    .dsp_mode_select_in(dsp_mode_select_in),
    .host_flag_zero_out(host_flag_zero_out),
    .host_flag_one_out(host_flag_one_out),
    .dsp_rx_word_full_out(dsp_rx_word_full_out),
    .dsp_rx_read_in(dsp_rx_read_in), .dsp_rx_event_out(dsp_rx_event_out)
);

// ==== hpc_host_model.sv ====
`timescale 1ns/1ps
module hpc_host_model (
    input  wire logic       clk_in,    // clock
    input  wire logic [7:0] rdata_in,  // device data
    input  wire logic       oe_in,     // device drives bus
    output logic            rd_out,    // read strobe
    output logic            wr_out,    // write strobe
    output logic            ack_out,   // dma acknowledge
    output logic [2:0]      addr_out,  // address
    output logic [7:0]      wdata_out  // write data
);
    initial begin
        {ack_out, wr_out, rd_out} = 3'h0;
        addr_out  = 3'h0;
        wdata_out = 8'h5A;
    end
    // kind 0 read, 1 write, 2 acknowledge; strobe held 8 cycles
    task automatic cycle(input int k, input logic [2:0] a,
                         input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        #1;
        addr_out  = a;
        wdata_out = d;
        {ack_out, wr_out, rd_out} = 3'(1 << k);
        repeat (8) @(posedge clk_in);
        q = oe_in ? rdata_in : 8'hXX;
        #1;
        {ack_out, wr_out, rd_out} = 3'h0;
        repeat (6) @(posedge clk_in);
        #1;
        wdata_out = ~d; // released bus shows no stale byte
        repeat (6) @(posedge clk_in);
    endtask : cycle
endmodule : hpc_host_model

// ==== test_host_port_control_dma_sequencer.sv ====
`timescale 1ns/1ps
module test_host_port_control_dma_sequencer;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        rd, wr, host_acknowledge_in, load = 1'b0, pop = 1'b0;
    logic [2:0]  ha, mode = 3'h0;
    logic [7:0]  hd, dout, q, wd;
    logic [23:0] txw = 24'h0, rxw, w;
    logic        oe, req, apo, apoe, vack, f0, f1, dte, rxf, rev, tev;
    logic [31:0] seed = 32'h0000_05DB;
    logic [7:0]  txb [1:3];
    logic [23:0] rxq [$];
    logic [23:0] txq [$];
    int          miscompares = 0, num_checks = 0;
    int          nvec = 0, nrev = 0, ntev = 0, n0, c, k, e;
    wire         ack_w = apoe ? apo : host_acknowledge_in;

    hpc_host_port dut (
        .clk_in(clk_in), .reset_in(reset_in), .host_read_in(rd),
        .host_write_in(wr), .host_addr_in(ha), .host_data_in(hd),
        .host_data_out(dout), .host_data_oe_out(oe),
        .request_pin_out(req), .ack_pin_in(ack_w), .ack_pin_out(apo),
        .ack_pin_oe_out(apoe), .vector_ack_out(vack),
        .dsp_mode_select_in(mode), .host_flag_zero_out(f0),
        .host_flag_one_out(f1), .dsp_tx_word_in(txw),
        .dsp_tx_load_in(load), .dsp_tx_word_empty_out(dte),
        .dsp_tx_event_out(tev), .dsp_rx_word_out(rxw),
        .dsp_rx_word_full_out(rxf), .dsp_rx_read_in(pop),
        .dsp_rx_event_out(rev)
    );
    hpc_host_model host (
        .clk_in(clk_in), .rdata_in(dout), .oe_in(oe), .rd_out(rd),
        .wr_out(wr), .ack_out(host_acknowledge_in), .addr_out(ha), .wdata_out(hd)
    );

    initial forever #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        nvec += (vack === 1'b1);
        nrev += (rev === 1'b1);
        ntev += (tev === 1'b1);
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input logic [7:0] g, x, input string m);
        num_checks++;
        if (g !== x) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask : chk
    task automatic chk_w(input logic [23:0] g, x, input string m);
        num_checks++;
        if (g !== x) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask : chk_w
    task automatic hrd(input logic [2:0] a);
        host.cycle(0, a, 8'h00, q);
    endtask : hrd
    task automatic hwr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] j;
        host.cycle(1, a, d, j);
    endtask : hwr
    task automatic hword(input logic [23:0] v);
        hwr(3'h5, v[23:16]);
        hwr(3'h6, v[15:8]);
        hwr(3'h7, v[7:0]);
        txq.push_back(v);
    endtask : hword
    task automatic put(input logic [23:0] v);
        int t;
        for (t = 0; t < 99 && dte !== 1'b1; t++) @(posedge clk_in);
        @(posedge clk_in);
        #1;
        txw  = v;
        load = 1'b1;
        @(posedge clk_in);
        #1;
        load = 1'b0;
        rxq.push_back(v);
    endtask : put
    task automatic drain();
        while (txq.size() > 0) begin
            @(posedge clk_in);
            #1;
            chk_w(rxw, txq.pop_front(), "fifo word");
            pop = 1'b1;
            @(posedge clk_in);
            #1;
            pop = 1'b0;
            repeat (3) @(posedge clk_in);
        end
        #1;
        chk({7'h0, rxf}, 8'h00, "fifo empty");
    endtask : drain
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    initial begin
        #200000;
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        hrd(hpc_pkg::ADDR_CTRL);
        chk(q, 8'h00, "ctrl reset");
        hrd(hpc_pkg::ADDR_STAT);
        chk(q, 8'h06, "status reset");
        for (k = 0; k < 3; k++) begin
            wd = 8'(rnd()) & 8'h7F;
            hwr(hpc_pkg::ADDR_CTRL, wd);
            hrd(hpc_pkg::ADDR_CTRL);
            chk(q, wd & 8'h3F, "ctrl rw");
            chk({6'h0, f1, f0}, {6'h0, wd[4:3]}, "flags");
        end
        for (k = 1; k < 8; k++) begin
            #1;
            mode = (k == 4) ? 3'h1 : 3'(k);
            hwr(hpc_pkg::ADDR_CTRL, 8'h03);
            hrd(hpc_pkg::ADDR_CTRL);
            chk(q, {1'b0, mode[1:0], 5'h03}, "mirror");
            chk({6'h0, apo, req}, 8'h00, "quiet");
        end
        #1;
        mode = hpc_pkg::MODE_PLAIN;
        $display("test control done");
        for (e = 0; e < 2; e++) begin
            put(24'(rnd()));
            for (k = 0; k < 8 && e == 0; k++) begin
                hwr(hpc_pkg::ADDR_CTRL, 8'(k));
                chk({6'h0, apo, req}, k[2] ? {6'h0, k[0], k[1]} :
                    {7'h0, |k[1:0]}, "pins");
                if (k == 1)
                    host.cycle(2, 3'h0, 8'h00, q);
            end
            hwr(hpc_pkg::ADDR_CTRL, e ? 8'h20 : 8'h00);
            w = rxq.pop_front();
            for (k = 5; k < 8; k++) begin
                hrd(3'(k));
                chk(q, 8'(w >> (8 * (e ? k - 5 : 7 - k))), "rx");
            end
            hrd(hpc_pkg::ADDR_STAT);
            chk({7'h0, q[0]}, 8'h00, "rx full clear");
        end
        chk(8'(nvec), 8'h01, "vector ack");
        chk(8'(ntev), 8'h02, "dsp word moves");
        $display("test requests done");
        hwr(hpc_pkg::ADDR_CTRL, 8'h00);
        n0 = nrev;
        for (k = 0; k < 9; k++) hword(24'(rnd()));
        hrd(hpc_pkg::ADDR_STAT);
        chk(q & 8'h07, 8'h00, "fifo full");
        chk(8'(nrev - n0), 8'h08, "word events");
        drain();
        $display("test fifo done");
        for (e = 0; e < 4; e++) begin
            hwr(hpc_pkg::ADDR_CTRL, 8'h83);
            put(24'(rnd()));
            put(24'(rnd()));
            hword(24'(rnd()));
            hwr(hpc_pkg::ADDR_CTRL, 8'(8'h80 | e));
            hrd(hpc_pkg::ADDR_CTRL);
            chk(q, 8'(e), "init clear");
            hrd(hpc_pkg::ADDR_STAT);
            chk({4'h0, q[1:0], dte, rxf},
                {5'h1, ~e[0], e[0], ~e[1]}, "init");
        end
        rxq.delete();
        txq.delete();
        hwr(hpc_pkg::ADDR_CTRL, 8'h83);
        drain();
        $display("test init done");
        mode = hpc_pkg::MODE_HOSTDMA;
        for (e = 1; e < 4; e++) begin
            hwr(hpc_pkg::ADDR_CTRL, 8'(8'h82 | (e << 5)));
            chk({7'h0, req}, 8'h01, "dma tx req");
            n0 = nrev;
            c = e;
            for (k = 0; k < 2 * (4 - e); k++) begin
                wd = 8'(rnd());
                txb[c] = wd;
                host.cycle(2, 3'h0, wd, q);
                if (c == 3) begin
                    txq.push_back({txb[1], txb[2], txb[3]});
                    c = e;
                end else begin
                    c++;
                end
            end
            chk(8'(nrev - n0), 8'h02, "dma events");
            drain();
        end
        hwr(hpc_pkg::ADDR_CTRL, 8'h23);
        chk({7'h0, req}, 8'h00, "reserved");
        hwr(hpc_pkg::ADDR_CTRL, 8'hA1);
        put(24'(rnd()));
        hrd(hpc_pkg::ADDR_STAT);
        chk({7'h0, q[7]}, 8'h01, "dma rx req");
        w = rxq.pop_front();
        for (k = 2; k >= 0; k--) begin
            host.cycle(2, 3'h0, 8'h00, q);
            chk(q, 8'(w >> (8 * k)), "dma rx");
        end
        $display("test dma done");
        stop_test();
    end
endmodule : test_host_port_control_dma_sequencer
